// [tdd_mem_model.sv]
// Remote sample memory model answering read requests after a selectable delay.
`timescale 1ns/1ps
`default_nettype none
module tdd_mem_model (
	input wire logic CORE_CLK,
	input wire logic MEM_RD,
	input wire logic [19:0] MEM_RADDR,
	input wire logic [2:0] lat,
	output logic MEM_ACK,
	output logic [11:0] MEM_RDATA,
	output logic [11:0] last_data,
	output logic [19:0] last_addr
);
	logic [2:0] wait_cnt;
	logic [11:0] word;
	// Bit two of the address feeds the sign so both signs appear at any stride that is not a multiple of eight.
	assign word = {MEM_RADDR[2], MEM_RADDR[10:0] ^ 11'h2a5};
	initial begin
		MEM_ACK = 1'b0;
		MEM_RDATA = 12'h000;
		wait_cnt = 3'h0;
	end
	always @(posedge CORE_CLK) begin
		if (MEM_RD && !MEM_ACK && wait_cnt >= lat) begin
			MEM_ACK <= 1'b1;
			MEM_RDATA <= word;
			last_data <= word;
			last_addr <= MEM_RADDR;
			wait_cnt <= 3'h0;
		end else begin
			MEM_ACK <= 1'b0;
			// Released data lines toggle so stale data never looks valid.
			MEM_RDATA <= ~MEM_RDATA;
			wait_cnt <= (MEM_RD && !MEM_ACK) ? wait_cnt + 3'h1 : 3'h0;
		end
	end
endmodule
`default_nettype wire

// [tdd_pkg.sv]
// Constants, field layouts and state types of the transient digitizer command logic.
`default_nettype none
package tdd_pkg;

	// ------------------------------------------------------------------
	// Dataway function and subaddress codes
	// ------------------------------------------------------------------
	localparam logic [4:0] F_READ = 5'h00;
	localparam logic [4:0] F_READ_BUF = 5'h02;
	localparam logic [4:0] F_READ_ID = 5'h06;
	localparam logic [4:0] F_WRITE = 5'h10;
	localparam logic [4:0] F_CTRL = 5'h19;
	localparam logic [3:0] A_0 = 4'h0;
	localparam logic [3:0] A_1 = 4'h1;
	localparam logic [3:0] A_2 = 4'h2;

	// The identity value is arbitrary.
	localparam logic [11:0] MODULE_ID = 12'h5a3;

	// ------------------------------------------------------------------
	// Modes, write-word and read-word field positions
	// ------------------------------------------------------------------
	localparam logic [1:0] MODE_CLEAR = 2'h0;
	localparam logic [1:0] MODE_POST = 2'h1;
	localparam logic [1:0] MODE_PRE = 2'h2;
	localparam logic [1:0] MODE_UNLOAD = 2'h3;
	localparam int ARM_MODE_BIT = 0;
	localparam int ARM_CLK_LSB = 1;
	localparam int ARM_CH_LSB = 5;
	localparam int ARM_BLK_LSB = 8;
	localparam int UNL_OFS_LSB = 0;
	localparam int UNL_CH_LSB = 18;
	localparam int ST_STATE_LSB = 3;
	localparam int ST_MEM_LSB = 5;
	localparam int ST_GAIN_LSB = 10;
	localparam int ST_NCH_LSB = 12;
	localparam int ST_CLK_LSB = 14;
	localparam int CNT_FULL_BIT = 19;
	localparam int BLOCK_SHIFT = 4;
	localparam logic [3:0] CLK_CODE_MAX = 4'h9;
	localparam int MEM_UNIT_SHIFT = 15;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned LED_MS = 100;
	localparam int unsigned CLEAR_S = 2;
	localparam int unsigned LED_CYC = CLK_HZ / 1000 * LED_MS;
	localparam int unsigned CLEAR_CYC = CLK_HZ * CLEAR_S;
	localparam int unsigned CYC_PER_100HZ = CLK_HZ / 100;

	// ------------------------------------------------------------------
	// State types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ARMED = 2'b01,
		ST_LOAD = 2'b11,
		ST_DONE = 2'b10
	} tdd_opst_e;

	typedef enum logic [1:0] {
		U_IDLE = 2'b00,
		U_WRAP = 2'b01,
		U_FETCH = 2'b11,
		U_READY = 2'b10
	} tdd_unl_e;

	typedef struct packed {
		logic busy;
		logic [27:0] busy_cnt;
		logic [1:0] mode;
		tdd_opst_e opst;
		logic pre;
		logic [3:0] clk_code;
		logic [1:0] nch_code;
		logic [15:0] blocks;
		logic [19:0] tick_div;
		logic ext_prev;
		logic trigger_seen_indicator_prev;
		logic [5:0] burst;
		logic [4:0] chan;
		logic [19:0] ptr;
		logic [20:0] words;
		logic full;
		logic [18:0] c0cnt;
		logic [19:0] post_left;
		logic [19:0] oldest;
		tdd_unl_e ust;
		logic [23:0] uaddr;
		logic [15:0] ubuf;
		logic [23:0] r;
		logic q;
		logic x;
		logic st_pulse;
		logic [23:0] n_led;
		logic [23:0] trigger_seen_indicator_led;
		logic [23:0] arm_led;
	} tdd_state_s;

	localparam tdd_state_s STATE_RST = '{busy: 1'b1, opst: ST_IDLE, ust: U_IDLE, default: '0};

endpackage

`default_nettype wire

// [tdd_top.sv]
// Dataway command interpreter, acquisition sequencer and unload logic of the digitizer.
`timescale 1ns/1ps
`default_nettype none

module tdd_top #(
	parameter int unsigned CYC_PER_100HZ = tdd_pkg::CYC_PER_100HZ,
	parameter int unsigned LED_CYC = tdd_pkg::LED_CYC,
	parameter int unsigned CLEAR_CYC = tdd_pkg::CLEAR_CYC
) (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic DW_STROBE,
	input wire logic DW_N,
	input wire logic [4:0] DW_F,
	input wire logic [3:0] DW_A,
	input wire logic [23:0] DW_W,
	input wire logic DW_Z,
	input wire logic DW_C,
	output logic [23:0] DW_R,
	output logic DW_Q,
	output logic DW_X,
	input wire logic EXT_CLK,
	input wire logic EXT_TRIGGER_SEEN_INDICATOR,
	input wire logic [4:0] MEM_SIZE_SW,
	input wire logic [1:0] GAIN_SW,
	output logic MEM_WR,
	output logic [19:0] MEM_WADDR,
	output logic [4:0] ADC_CHAN,
	output logic MEM_RD,
	output logic [19:0] MEM_RADDR,
	input wire logic MEM_ACK,
	input wire logic [11:0] MEM_RDATA,
	output logic MEM_CLEAR,
	output logic SELF_TEST,
	output logic LED_N,
	output logic LED_ARMED,
	output logic LED_ACT,
	output logic LED_EOR,
	output logic LED_TRIGGER_SEEN_INDICATOR
);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [19:0] div_for(input logic [3:0] code);
		int unsigned rate;
		rate = 1;
		unique case (code)
			4'h1: rate = 400;
			4'h2: rate = 200;
			4'h3: rate = 100;
			4'h4: rate = 50;
			4'h5: rate = 20;
			4'h6: rate = 10;
			4'h7: rate = 5;
			4'h8: rate = 2;
			default: rate = 1;
		endcase
		return 20'(CYC_PER_100HZ / rate);
	endfunction

	function automatic logic [1:0] state_num(input tdd_pkg::tdd_opst_e st);
		logic [1:0] v;
		v = 2'h0;
		unique case (st)
			tdd_pkg::ST_IDLE: v = 2'h0;
			tdd_pkg::ST_ARMED: v = 2'h1;
			tdd_pkg::ST_LOAD: v = 2'h2;
			tdd_pkg::ST_DONE: v = 2'h3;
		endcase
		return v;
	endfunction

	tdd_pkg::tdd_state_s s;
	tdd_pkg::tdd_state_s next_s;

	logic [5:0] nch;
	logic [2:0] nch_shift;
	logic [20:0] memsize;
	logic loading;
	logic tick;
	logic ext_rise;
	logic trigger_seen_indicator_rise;
	logic take;
	logic sw_trigger_seen_indicator;
	logic trigger_seen_indicator;
	logic [19:0] ptr_inc;
	logic [4:0] req_ch;

	assign nch = 6'd32 >> s.nch_code;
	assign nch_shift = 3'd5 - 3'(s.nch_code);
	assign memsize = {6'(MEM_SIZE_SW) + 6'd1, 15'h0};
	assign loading = (s.opst == tdd_pkg::ST_LOAD) || (s.opst == tdd_pkg::ST_ARMED && s.pre);
	assign ext_rise = EXT_CLK & ~s.ext_prev;
	assign trigger_seen_indicator_rise = EXT_TRIGGER_SEEN_INDICATOR & ~s.trigger_seen_indicator_prev;
	assign take = DW_STROBE & DW_N & ~s.busy;
	assign ptr_inc = s.ptr + 20'd1;
	assign req_ch = DW_W[tdd_pkg::UNL_CH_LSB +: 5];

	// Unassigned clock codes produce no tick at all.
	always_comb begin
		tick = 1'b0;
		if (s.clk_code == 4'h0) begin
			tick = ext_rise;
		end else if (s.clk_code <= tdd_pkg::CLK_CODE_MAX) begin
			tick = (s.tick_div == div_for(s.clk_code) - 20'd1);
		end
	end

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		next_s = s;
		sw_trigger_seen_indicator = 1'b0;
		next_s.ext_prev = EXT_CLK;
		next_s.trigger_seen_indicator_prev = EXT_TRIGGER_SEEN_INDICATOR;
		next_s.st_pulse = 1'b0;
		if (s.n_led != 24'h0) begin
			next_s.n_led = s.n_led - 24'h1;
		end
		if (s.trigger_seen_indicator_led != 24'h0) begin
			next_s.trigger_seen_indicator_led = s.trigger_seen_indicator_led - 24'h1;
		end
		if (s.arm_led != 24'h0) begin
			next_s.arm_led = s.arm_led - 24'h1;
		end

		// Dataway commands, answered one cycle after the strobe.
		if (take) begin
			next_s.n_led = 24'(LED_CYC - 1);
			next_s.r = 24'h0;
			next_s.q = 1'b0;
			next_s.x = 1'b0;
			unique case (DW_F)
				tdd_pkg::F_READ: begin
					next_s.x = (DW_A == tdd_pkg::A_0) || (DW_A == tdd_pkg::A_1)
						|| (DW_A == tdd_pkg::A_2);
					next_s.q = next_s.x;
					if (DW_A == tdd_pkg::A_0) begin
						next_s.r = 24'(s.mode)
							| (24'(state_num(s.opst)) << tdd_pkg::ST_STATE_LSB)
							| (24'(MEM_SIZE_SW) << tdd_pkg::ST_MEM_LSB)
							| (24'(GAIN_SW) << tdd_pkg::ST_GAIN_LSB)
							| (24'(s.nch_code) << tdd_pkg::ST_NCH_LSB)
							| (24'(s.clk_code) << tdd_pkg::ST_CLK_LSB);
					end else if (DW_A == tdd_pkg::A_1) begin
						next_s.r = 24'(s.blocks);
					end else if (DW_A == tdd_pkg::A_2) begin
						next_s.r = 24'(s.c0cnt);
						next_s.r[tdd_pkg::CNT_FULL_BIT] = s.full;
					end
				end
				tdd_pkg::F_READ_BUF: begin
					next_s.x = 1'b1;
					if (s.mode == tdd_pkg::MODE_UNLOAD && s.ust == tdd_pkg::U_READY) begin
						next_s.q = 1'b1;
						next_s.r = 24'(s.ubuf);
						next_s.uaddr = s.uaddr
							+ ((24'(DW_A) + 24'h1) << nch_shift);
						next_s.ust = tdd_pkg::U_WRAP;
					end // Otherwise Q and data stay zero.
				end
				tdd_pkg::F_READ_ID: begin
					if (DW_A == tdd_pkg::A_0) begin
						next_s.x = 1'b1;
						next_s.q = 1'b1;
						next_s.r = 24'(tdd_pkg::MODULE_ID);
					end
				end
				tdd_pkg::F_WRITE: begin
					if (DW_A == tdd_pkg::A_0) begin
						next_s.x = 1'b1;
						next_s.q = 1'b1;
						next_s.opst = tdd_pkg::ST_ARMED;
						next_s.pre = DW_W[tdd_pkg::ARM_MODE_BIT];
						next_s.mode = DW_W[tdd_pkg::ARM_MODE_BIT] ? tdd_pkg::MODE_PRE
							: tdd_pkg::MODE_POST;
						next_s.clk_code = DW_W[tdd_pkg::ARM_CLK_LSB +: 4];
						next_s.nch_code = DW_W[tdd_pkg::ARM_CH_LSB +: 2];
						next_s.blocks = DW_W[tdd_pkg::ARM_BLK_LSB +: 16];
						next_s.ptr = 20'h0;
						next_s.words = 21'h0;
						next_s.full = 1'b0;
						next_s.c0cnt = 19'h0;
						next_s.burst = 6'h0;
						next_s.tick_div = 20'h0;
						next_s.ust = tdd_pkg::U_IDLE;
						next_s.arm_led = 24'(LED_CYC - 1);
					end else if (DW_A == tdd_pkg::A_1) begin
						next_s.x = 1'b1;
						// Count of channel zero samples shows whether anything was taken.
						if (s.c0cnt != 19'h0 && 6'(req_ch) < nch) begin
							next_s.q = 1'b1;
							next_s.mode = tdd_pkg::MODE_UNLOAD;
							next_s.uaddr = 24'(s.oldest)
								+ (24'(DW_W[tdd_pkg::UNL_OFS_LSB +: 18]) << nch_shift)
								+ 24'(req_ch);
							next_s.ust = tdd_pkg::U_WRAP;
						end
					end
				end
				tdd_pkg::F_CTRL: begin
					if (DW_A == tdd_pkg::A_0) begin
						next_s.x = 1'b1;
						next_s.q = 1'b1;
						next_s.opst = tdd_pkg::ST_DONE;
						next_s.burst = 6'h0;
						next_s.oldest = s.full ? s.ptr : 20'h0;
					end else if (DW_A == tdd_pkg::A_1) begin
						next_s.x = 1'b1;
						next_s.q = (s.opst == tdd_pkg::ST_ARMED);
						next_s.st_pulse = (s.opst == tdd_pkg::ST_ARMED);
					end else if (DW_A == tdd_pkg::A_2) begin
						next_s.x = 1'b1;
						next_s.q = (s.opst == tdd_pkg::ST_ARMED);
						sw_trigger_seen_indicator = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end

		// Trigger: external edge and software trigger share one path.
		trigger_seen_indicator = trigger_seen_indicator_rise | sw_trigger_seen_indicator;
		if (trigger_seen_indicator && s.opst == tdd_pkg::ST_ARMED && next_s.opst == tdd_pkg::ST_ARMED) begin
			next_s.opst = tdd_pkg::ST_LOAD;
			next_s.post_left = 20'(s.blocks) << tdd_pkg::BLOCK_SHIFT;
			next_s.trigger_seen_indicator_led = 24'(LED_CYC - 1);
			next_s.arm_led = 24'h0;
		end

		// Sample bursts: one write per active channel per tick; idle, done and a post-trigger arm ignore it.
		// An arm in mid-burst must win, or the pointer would not restart at zero.
		if (loading && next_s.opst != tdd_pkg::ST_DONE
			&& !(take && DW_F == tdd_pkg::F_WRITE && DW_A == tdd_pkg::A_0)) begin
			next_s.tick_div = tick ? 20'h0 : s.tick_div + 20'h1;
			if (s.burst != 6'h0) begin
				next_s.burst = s.burst - 6'h1;
				next_s.chan = s.chan + 5'h1;
				next_s.ptr = (21'(ptr_inc) == memsize) ? 20'h0 : ptr_inc;
				next_s.words = (s.words == memsize) ? s.words : s.words + 21'h1;
				if (s.words + 21'h1 >= memsize) begin
					next_s.full = 1'b1;
				end
				if (s.burst == 6'h1) begin
					if (s.c0cnt != 19'h7ffff) begin
						next_s.c0cnt = s.c0cnt + 19'h1;
					end
					if (s.opst == tdd_pkg::ST_LOAD) begin
						next_s.post_left = s.post_left - 20'h1;
						if ((next_s.full && !s.pre)
							|| ((s.pre || s.blocks != 16'h0) && s.post_left <= 20'h1)) begin
							next_s.opst = tdd_pkg::ST_DONE;
							next_s.oldest = next_s.full ? next_s.ptr : 20'h0;
						end
					end
				end
			end else if (tick) begin
				next_s.burst = nch;
				next_s.chan = 5'h0;
			end
		end else begin
			next_s.tick_div = 20'h0;
		end

		// Unload fetch; the wrap is at most one step after a read, so the refill stays short.
		unique case (s.ust)
			tdd_pkg::U_IDLE: begin
			end
			tdd_pkg::U_WRAP: begin
				if (take && DW_F == tdd_pkg::F_WRITE) begin
				end else if (s.uaddr >= 24'(memsize)) begin
					next_s.uaddr = s.uaddr - 24'(memsize);
				end else begin
					next_s.ust = tdd_pkg::U_FETCH;
				end
			end
			tdd_pkg::U_FETCH: begin
				if (MEM_ACK && !(take && DW_F == tdd_pkg::F_WRITE)) begin
					next_s.ubuf = {{4{MEM_RDATA[11]}}, MEM_RDATA};
					next_s.ust = tdd_pkg::U_READY;
				end
			end
			tdd_pkg::U_READY: begin
			end
		endcase

		// Clear and initialize: restart the wipe and hold the dataway off.
		if (s.busy) begin
			next_s.busy_cnt = s.busy_cnt + 28'h1;
			if (s.busy_cnt >= 28'(CLEAR_CYC - 1)) begin
				next_s.busy = 1'b0;
			end
		end
		if (DW_Z || DW_C) begin
			next_s = tdd_pkg::STATE_RST;
			next_s.ext_prev = EXT_CLK;
			next_s.trigger_seen_indicator_prev = EXT_TRIGGER_SEEN_INDICATOR;
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			s <= tdd_pkg::STATE_RST;
		end else if (CE) begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign DW_R = s.r;
	assign DW_Q = s.q;
	assign DW_X = s.x;
	assign MEM_WR = (s.burst != 6'h0);
	assign MEM_WADDR = s.ptr;
	assign ADC_CHAN = s.chan;
	assign MEM_RD = (s.ust == tdd_pkg::U_FETCH);
	assign MEM_RADDR = s.uaddr[19:0];
	assign MEM_CLEAR = s.busy;
	assign SELF_TEST = s.st_pulse;
	assign LED_N = (s.n_led != 24'h0);
	assign LED_TRIGGER_SEEN_INDICATOR = (s.trigger_seen_indicator_led != 24'h0);
	// The minimum armed time only holds when arming ends through the F25 stop command, not on a trigger or a clear.
	assign LED_ARMED = (s.opst == tdd_pkg::ST_ARMED)
		|| (s.arm_led != 24'h0 && s.opst != tdd_pkg::ST_LOAD);
	assign LED_ACT = loading;
	assign LED_EOR = (s.opst == tdd_pkg::ST_DONE);

endmodule

`default_nettype wire

// [tdd_top_properties.sv]
// Concurrent checks on the dataway, memory and indicator ports of the digitizer command logic.
`timescale 1ns/1ps
`default_nettype none
module tdd_top_properties (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic DW_STROBE,
	input wire logic DW_N,
	input wire logic [4:0] DW_F,
	input wire logic [3:0] DW_A,
	input wire logic DW_Z,
	input wire logic DW_C,
	input wire logic [23:0] DW_R,
	input wire logic DW_Q,
	input wire logic DW_X,
	input wire logic MEM_WR,
	input wire logic [4:0] ADC_CHAN,
	input wire logic MEM_CLEAR,
	input wire logic SELF_TEST,
	input wire logic LED_N,
	input wire logic LED_TRIGGER_SEEN_INDICATOR,
	input wire logic LED_EOR,
	input wire logic LED_ARMED
);
	// ------------------------------------------------------------------
	// Command qualification
	// ------------------------------------------------------------------
	logic taken;
	logic known;
	assign taken = CE && DW_STROBE && DW_N && !MEM_CLEAR && !DW_Z && !DW_C;
	assign known = DW_F inside {tdd_pkg::F_READ, tdd_pkg::F_READ_BUF, tdd_pkg::F_READ_ID,
		tdd_pkg::F_WRITE, tdd_pkg::F_CTRL};
	default clocking @(posedge CORE_CLK);
	endclocking
	default disable iff (!RST_N);

	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	id_read_a: assert property (taken && DW_F == tdd_pkg::F_READ_ID && DW_A == tdd_pkg::A_0 |=>
		DW_R == {12'h000, tdd_pkg::MODULE_ID} && DW_Q && DW_X) else $error("identity answer wrong");
	unknown_cmd_a: assert property (taken && !known |=> DW_R == 24'h000000 && !DW_Q && !DW_X)
		else $error("unknown command answered");
	selftest_gate_a: assert property (taken && DW_F == tdd_pkg::F_CTRL && DW_A == tdd_pkg::A_1
		|=> SELF_TEST == DW_Q) else $error("self test start disagrees with Q");
	busy_hold_a: assert property (MEM_CLEAR && $past(MEM_CLEAR) |->
		$stable(DW_R) && $stable(DW_Q) && $stable(DW_X)) else $error("answer changed while busy");
	clear_entry_a: assert property (CE && (DW_Z || DW_C) |=> MEM_CLEAR && DW_R == 24'h000000
		&& !LED_ARMED && !LED_EOR) else $error("clear did not reset module");
	eor_quiet_a: assert property (LED_EOR && $past(LED_EOR) |-> !MEM_WR)
		else $error("memory written after end of record");
	burst_order_a: assert property (MEM_WR |-> ADC_CHAN == (!$past(CE) ? $past(ADC_CHAN)
		: $past(MEM_WR) ? $past(ADC_CHAN) + 5'h01 : 5'h00)) else $error("channel order wrong");
	trigger_seen_indicator_stretch_a: assert property ($rose(LED_TRIGGER_SEEN_INDICATOR) |-> LED_TRIGGER_SEEN_INDICATOR [*8])
		else $error("trigger lamp too short");
	n_stretch_a: assert property (taken |=> LED_N [*8]) else $error("station lamp too short");
endmodule
bind tdd_top tdd_top_properties tdd_top_properties_inst (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
	.CE(CE), .DW_STROBE(DW_STROBE), .DW_N(DW_N), .DW_F(DW_F), .DW_A(DW_A), .DW_Z(DW_Z),
	.DW_C(DW_C), .DW_R(DW_R), .DW_Q(DW_Q), .DW_X(DW_X), .MEM_WR(MEM_WR), .ADC_CHAN(ADC_CHAN),
	.MEM_CLEAR(MEM_CLEAR), .SELF_TEST(SELF_TEST), .LED_N(LED_N), .LED_TRIGGER_SEEN_INDICATOR(LED_TRIGGER_SEEN_INDICATOR),
	.LED_EOR(LED_EOR), .LED_ARMED(LED_ARMED));
`default_nettype wire

// [transient_digitizer_dataway_commands_tb.sv]
// Self-checking testbench of the digitizer dataway command logic.
`timescale 1ns/1ps
`default_nettype none
module transient_digitizer_dataway_commands_tb;
	logic core_clk, rst_n, dw_strobe, dw_c, ext_clk, ext_trigger_seen_indicator, mem_wr, mem_rd, mem_ack;
	logic dw_q, dw_x, mem_clear, self_test, led_armed, led_act, led_eor, led_trigger_seen_indicator;
	logic ce, dw_z, led_n;
	logic [19:0] mem_waddr;
	logic [4:0] dw_f;
	logic [3:0] dw_a;
	logic [23:0] dw_w, dw_r;
	logic [19:0] mem_raddr, last_addr, prev;
	logic [11:0] mem_rdata, last_data;
	logic [2:0] lat;
	logic [31:0] seed;
	logic [3:0] x;
	int failures, checks_done, wr_cnt;

	tdd_top #(.CYC_PER_100HZ(400), .LED_CYC(20), .CLEAR_CYC(10)) tdd_top_inst (
		.CORE_CLK(core_clk), .RST_N(rst_n), .CE(ce), .DW_STROBE(dw_strobe), .DW_N(1'b1),
		.DW_F(dw_f), .DW_A(dw_a), .DW_W(dw_w), .DW_Z(dw_z), .DW_C(dw_c), .DW_R(dw_r),
		.DW_Q(dw_q), .DW_X(dw_x), .EXT_CLK(ext_clk), .EXT_TRIGGER_SEEN_INDICATOR(ext_trigger_seen_indicator), .MEM_SIZE_SW(5'h00),
		.GAIN_SW(2'h2), .MEM_WR(mem_wr), .MEM_WADDR(mem_waddr), .ADC_CHAN(), .MEM_RD(mem_rd),
		.MEM_RADDR(mem_raddr), .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata), .MEM_CLEAR(mem_clear),
		.SELF_TEST(self_test), .LED_N(led_n), .LED_ARMED(led_armed), .LED_ACT(led_act),
		.LED_EOR(led_eor), .LED_TRIGGER_SEEN_INDICATOR(led_trigger_seen_indicator));
	tdd_mem_model tdd_mem_model_inst (.CORE_CLK(core_clk), .MEM_RD(mem_rd), .MEM_RADDR(mem_raddr),
		.lat(lat), .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata), .last_data(last_data),
		.last_addr(last_addr));

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic logic [23:0] sext(input logic [11:0] d);
		return {8'h00, {4{d[11]}}, d};
	endfunction
	task automatic tally_and_finish();
		if (failures == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk_word(input string name, input logic [23:0] exp, input logic [23:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic chk_bit(input string name, input logic exp, input logic got);
		chk_word(name, {23'h0, exp}, {23'h0, got});
	endtask
	task automatic cmd(input logic [4:0] f, input logic [3:0] a, input logic [23:0] w);
		@(posedge core_clk);
		#1;
		dw_strobe = 1'b1;
		dw_f = f;
		dw_a = a;
		dw_w = w;
		@(posedge core_clk);
		#1;
		dw_strobe = 1'b0;
		dw_w = ~w;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic tick(input int n);
		repeat (n) begin
			ext_clk = 1'b1;
			cyc(5);
			ext_clk = 1'b0;
			cyc(15);
		end
	endtask
	task automatic wait_on(ref logic sig, input logic lvl, input int lim);
		int n;
		n = 0;
		while (sig !== lvl && n < lim) begin
			cyc(1);
			n++;
		end
		chk_bit("handshake", lvl, sig);
	endtask

	always @(posedge core_clk) if (mem_wr === 1'b1) wr_cnt++;
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		#300000;
		failures++;
		tally_and_finish();
	end

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	initial begin
		{rst_n, dw_strobe, dw_c, dw_z, ext_clk, ext_trigger_seen_indicator, dw_f, dw_a, dw_w} = '0;
		ce = 1'b1;
		lat = 3'h1;
		seed = 32'd12245;
		cyc(20);
		rst_n = 1'b1;
		wait_on(mem_clear, 1'b0, 100);
		cmd(tdd_pkg::F_READ_ID, tdd_pkg::A_0, 24'h0);
		chk_word("identity", {12'h0, tdd_pkg::MODULE_ID}, dw_r);
		chk_bit("station led", 1'b1, led_n);
		repeat (4) begin
			seed = xs(seed);
			// Function codes 8 to 15 are never decoded, unlike 24 to 31 which hold F25.
			cmd({2'b01, seed[2:0]}, seed[6:3], seed[31:8]);
			chk_bit("x unknown", 1'b0, dw_x);
		end
		cmd(tdd_pkg::F_READ_BUF, tdd_pkg::A_0, 24'h0);
		chk_word("early buffer", 24'h0, dw_r);
		chk_bit("early q", 1'b0, dw_q);
		cmd(tdd_pkg::F_CTRL, tdd_pkg::A_1, 24'h0);
		chk_bit("test idle q", 1'b0, dw_q);
		chk_bit("test idle pulse", 1'b0, self_test);
		chk_bit("test idle x", 1'b1, dw_x);
		cmd(tdd_pkg::F_WRITE, tdd_pkg::A_0, 24'h000160);
		chk_bit("arm q", 1'b1, dw_q);
		cmd(tdd_pkg::F_READ, tdd_pkg::A_0, 24'h0);
		chk_word("status", {6'h0, 4'h0, 2'h3, 2'h2, 5'h00, 2'h1, 1'b0, tdd_pkg::MODE_POST}, dw_r);
		chk_bit("armed led", 1'b1, led_armed);
		wr_cnt = 0;
		tick(2);
		chk_word("pre trigger writes", 24'h0, 24'(wr_cnt));
		chk_bit("station led off", 1'b0, led_n);
		cmd(tdd_pkg::F_CTRL, tdd_pkg::A_2, 24'h0);
		chk_bit("trigger q", 1'b1, dw_q);
		cyc(2);
		chk_bit("trigger_seen_indicator led", 1'b1, led_trigger_seen_indicator);
		chk_word("lamps", 24'h2, {22'h0, led_act, led_armed});
		tick(20);
		chk_word("post writes", 24'd64, 24'(wr_cnt));
		chk_word("write address", 24'd64, 24'(mem_waddr));
		chk_bit("eor led", 1'b1, led_eor);
		cmd(tdd_pkg::F_READ, tdd_pkg::A_2, 24'h0);
		chk_word("ch0 count", 24'd16, dw_r);
		cmd(tdd_pkg::F_WRITE, tdd_pkg::A_1, {1'b0, 5'd5, 18'h2});
		chk_bit("bad channel q", 1'b0, dw_q);
		// With the clock enable low a strobe must leave the previous answer standing.
		ce = 1'b0;
		cmd(tdd_pkg::F_READ_ID, tdd_pkg::A_0, 24'h0);
		chk_word("frozen answer", 24'h0, dw_r);
		chk_bit("frozen q", 1'b0, dw_q);
		ce = 1'b1;
		cmd(tdd_pkg::F_WRITE, tdd_pkg::A_1, {1'b0, 5'd1, 18'h2});
		chk_bit("unload q", 1'b1, dw_q);
		wait_on(mem_ack, 1'b1, 200);
		cyc(3);
		prev = last_addr;
		for (int i = 0; i < 6; i++) begin
			seed = xs(seed);
			x = seed[3:0];
			lat = seed[4] ? 3'h4 : 3'h0;
			cmd(tdd_pkg::F_READ_BUF, x, 24'h0);
			chk_word("buffer", sext(last_data), dw_r);
			chk_bit("buffer q", 1'b1, dw_q);
			if (i == 0) begin
				lat = 3'h4;
				cmd(tdd_pkg::F_READ_BUF, x, 24'h0);
				chk_bit("refill q", 1'b0, dw_q);
			end
			wait_on(mem_ack, 1'b1, 200);
			cyc(3);
			chk_word("stride", {4'h0, prev + 20'((x + 1) * 4)}, {4'h0, last_addr});
			prev = last_addr;
		end
		cmd(tdd_pkg::F_WRITE, tdd_pkg::A_0, 24'h000160);
		chk_word("pointer reset", 24'h0, 24'(mem_waddr));
		cmd(tdd_pkg::F_CTRL, tdd_pkg::A_1, 24'h0);
		chk_bit("test armed q", 1'b1, dw_q);
		chk_bit("test pulse", 1'b1, self_test);
		cmd(tdd_pkg::F_CTRL, tdd_pkg::A_0, 24'h0);
		cyc(2);
		chk_bit("forced eor", 1'b1, led_eor);
		cmd(tdd_pkg::F_CTRL, tdd_pkg::A_1, 24'h0);
		chk_bit("test done q", 1'b0, dw_q);
		cmd(tdd_pkg::F_WRITE, tdd_pkg::A_0, 24'h00016d);
		chk_bit("eor cleared", 1'b0, led_eor);
		cyc(300);
		chk_word("pre lamps", 24'h3, {22'h0, led_act, led_armed});
		ext_trigger_seen_indicator = 1'b1;
		cyc(3);
		ext_trigger_seen_indicator = 1'b0;
		wr_cnt = 0;
		wait_on(led_eor, 1'b1, 1000);
		chk_word("pre post writes", 24'd64, 24'(wr_cnt));
		cmd(tdd_pkg::F_WRITE, tdd_pkg::A_0, 24'h000177);
		wr_cnt = 0;
		cyc(500);
		chk_word("no clock writes", 24'h0, 24'(wr_cnt));
		dw_c = 1'b1;
		cyc(1);
		dw_c = 1'b0;
		chk_bit("clear busy", 1'b1, mem_clear);
		wait_on(mem_clear, 1'b0, 100);
		cmd(tdd_pkg::F_READ, tdd_pkg::A_0, 24'h0);
		chk_word("cleared state", {12'h0, 2'h2, 10'h0}, dw_r);
		cmd(tdd_pkg::F_WRITE, tdd_pkg::A_0, 24'h000160);
		cyc(10);
		dw_z = 1'b1;
		cyc(1);
		dw_z = 1'b0;
		chk_bit("init busy", 1'b1, mem_clear);
		chk_bit("init armed", 1'b0, led_armed);
		wait_on(mem_clear, 1'b0, 100);
		tally_and_finish();
	end
endmodule
`default_nettype wire
